// File: hw/dmauc_map.vh
`ifndef DMAUC_MAP_VH
`define DMAUC_MAP_VH

// register byte offsets
`define DMAUC_OFF_IRQ_FLAGS 8'h00
`define DMAUC_OFF_IRQ_MASK 8'h04
`define DMAUC_OFF_SER_START 8'h08
`define DMAUC_OFF_SER_STATUS 8'h0C
`define DMAUC_OFF_OP_CTRL 8'h10
`define DMAUC_OFF_MODE_CTRL 8'h14
`define DMAUC_OFF_SFR_ADDR 8'h18
`define DMAUC_OFF_RAM_ADDR 8'h1C
`define DMAUC_OFF_COUNT 8'h20

// irq flag / mask field positions
`define DMAUC_B_RX_ERROR 7
`define DMAUC_B_RX_END 6
`define DMAUC_B_DMA_END 3
`define DMAUC_IRQ_IMPL 8'hC8

// serial start / status
`define DMAUC_B_SER_CH1 1

// operation control
`define DMAUC_B_CH_EN 7
`define DMAUC_B_XFER_STAT 0

// mode control
`define DMAUC_B_SW_TRIG 7
`define DMAUC_B_DIR 6
`define DMAUC_B_SIZE 5
`define DMAUC_B_HOLD 4
`define DMAUC_SRC_HI 3
`define DMAUC_SRC_SERIAL0_RX 4'h7

// reset values
`define DMAUC_RST_FLAGS 8'h00
`define DMAUC_RST_MASK 8'hFF
`define DMAUC_RST_MODE 7'h00

// axi responses
`define DMAUC_RESP_OKAY 2'h0
`define DMAUC_RESP_SLVERR 2'h2

`endif

// File: hw/dmauc_top.v
`timescale 1ns/1ps
`include "dmauc_map.vh"

module dmauc_top #(
  parameter ADDR_W = 8
) (
  // clock, reset, enable
  input wire clk,
  input wire nrst,
  input wire ce,
  // axi4-lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // serial receive unit
  input wire rx_end,
  input wire rx_error,
  input wire [7:0] rx_data,
  output wire serial_ch1_enable,
  // transfer port
  output wire xfer_strobe,
  output wire xfer_dir,
  output wire xfer_size,
  output wire [7:0] xfer_sfr_addr,
  output wire [15:0] xfer_ram_addr,
  output wire [15:0] xfer_wdata,
  // misc
  output wire dma_clk_en,
  output wire irq
);

  function [15:0] unit_step;
    input size;
    begin
      unit_step = size ? 16'h0002 : 16'h0001;
    end
  endfunction

  // bus slave state
  reg aw_have_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg w_have_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;

  // block registers
  reg [7:0] irq_request_flags_high_reg;
  reg [7:0] irq_mask_flags_high_reg;
  reg serial_ch1_enabled_status_reg;
  reg channel_enable_reg;
  reg transfer_mode_status_reg;
  reg [6:0] dma_mode_control_reg;
  reg [7:0] sfr_addr_reg;
  reg [15:0] ram_addr_reg;
  reg [15:0] count_reg;
  reg pending_reg;
  reg strobe_reg;
  reg [15:0] xfer_ram_addr_reg;
  reg [15:0] xfer_wdata_reg;

  wire do_write = aw_have_reg && w_have_reg && !bvalid_reg;
  wire lane0 = w_strb_reg[0];
  wire lane1 = w_strb_reg[1];
  wire do_read = s_axi_arvalid && !rvalid_reg;

  // write decode
  reg sel_flags, sel_mask, sel_sstart, sel_ctrl, sel_mode;
  reg sel_sfr, sel_ram, sel_cnt, wr_hit;
  always @* begin
    sel_flags = 1'b0;
    sel_mask = 1'b0;
    sel_sstart = 1'b0;
    sel_ctrl = 1'b0;
    sel_mode = 1'b0;
    sel_sfr = 1'b0;
    sel_ram = 1'b0;
    sel_cnt = 1'b0;
    wr_hit = 1'b1;
    if (aw_addr_reg == `DMAUC_OFF_IRQ_FLAGS) begin
      sel_flags = do_write;
    end else if (aw_addr_reg == `DMAUC_OFF_IRQ_MASK) begin
      sel_mask = do_write;
    end else if (aw_addr_reg == `DMAUC_OFF_SER_START) begin
      sel_sstart = do_write;
    end else if (aw_addr_reg == `DMAUC_OFF_SER_STATUS) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == `DMAUC_OFF_OP_CTRL) begin
      sel_ctrl = do_write;
    end else if (aw_addr_reg == `DMAUC_OFF_MODE_CTRL) begin
      sel_mode = do_write;
    end else if (aw_addr_reg == `DMAUC_OFF_SFR_ADDR) begin
      sel_sfr = do_write;
    end else if (aw_addr_reg == `DMAUC_OFF_RAM_ADDR) begin
      sel_ram = do_write;
    end else if (aw_addr_reg == `DMAUC_OFF_COUNT) begin
      sel_cnt = do_write;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // read decode
  reg [31:0] rd_val;
  reg rd_hit;
  always @* begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    if (s_axi_araddr == `DMAUC_OFF_IRQ_FLAGS) begin
      rd_val[7:0] = irq_request_flags_high_reg;
    end else if (s_axi_araddr == `DMAUC_OFF_IRQ_MASK) begin
      rd_val[7:0] = irq_mask_flags_high_reg;
    end else if (s_axi_araddr == `DMAUC_OFF_SER_START) begin
      rd_val = 32'h00000000;
    end else if (s_axi_araddr == `DMAUC_OFF_SER_STATUS) begin
      rd_val[`DMAUC_B_SER_CH1] = serial_ch1_enabled_status_reg;
    end else if (s_axi_araddr == `DMAUC_OFF_OP_CTRL) begin
      rd_val[`DMAUC_B_CH_EN] = channel_enable_reg;
      rd_val[`DMAUC_B_XFER_STAT] = transfer_mode_status_reg;
    end else if (s_axi_araddr == `DMAUC_OFF_MODE_CTRL) begin
      // trigger bit is write-only and reads zero
      rd_val[6:0] = dma_mode_control_reg;
    end else if (s_axi_araddr == `DMAUC_OFF_SFR_ADDR) begin
      rd_val[7:0] = sfr_addr_reg;
    end else if (s_axi_araddr == `DMAUC_OFF_RAM_ADDR) begin
      rd_val[15:0] = ram_addr_reg;
    end else if (s_axi_araddr == `DMAUC_OFF_COUNT) begin
      rd_val[15:0] = count_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // channel control
  wire mode_dir = dma_mode_control_reg[`DMAUC_B_DIR];
  wire mode_size = dma_mode_control_reg[`DMAUC_B_SIZE];
  wire mode_hold = dma_mode_control_reg[`DMAUC_B_HOLD];
  wire [3:0] mode_src = dma_mode_control_reg[`DMAUC_SRC_HI:0];
  wire armed = channel_enable_reg && transfer_mode_status_reg;
  wire hw_req = armed && rx_end &&
    (mode_src == `DMAUC_SRC_SERIAL0_RX);
  wire sw_req = armed && sel_mode && lane0 &&
    w_data_reg[`DMAUC_B_SW_TRIG];
  wire any_req = hw_req || sw_req || pending_reg;
  // a disabling write beats a request landing in the same cycle
  wire stop_wr = sel_ctrl && lane0 && !w_data_reg[`DMAUC_B_CH_EN];
  wire go = any_req && !mode_hold && armed && !stop_wr;
  wire last = (count_reg <= 16'h0001);
  wire dma_done = go && last;

  // sticky flag sets; set beats a same-cycle clear
  wire [7:0] flag_set = {rx_error, rx_end, 2'b00, dma_done, 3'b000};
  wire [7:0] flag_clr = (sel_flags && lane0) ?
    (w_data_reg[7:0] & `DMAUC_IRQ_IMPL) : 8'h00;

  always @(posedge clk) begin
    if (!nrst) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `DMAUC_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `DMAUC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_have_reg) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_reg) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? `DMAUC_RESP_OKAY : `DMAUC_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (do_read) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_val;
        rresp_reg <= rd_hit ? `DMAUC_RESP_OKAY : `DMAUC_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      irq_request_flags_high_reg <= `DMAUC_RST_FLAGS;
      irq_mask_flags_high_reg <= `DMAUC_RST_MASK;
      serial_ch1_enabled_status_reg <= 1'b0;
      channel_enable_reg <= 1'b0;
      transfer_mode_status_reg <= 1'b0;
      dma_mode_control_reg <= `DMAUC_RST_MODE;
      sfr_addr_reg <= 8'h00;
      ram_addr_reg <= 16'h0000;
      count_reg <= 16'h0000;
      pending_reg <= 1'b0;
      strobe_reg <= 1'b0;
      xfer_ram_addr_reg <= 16'h0000;
      xfer_wdata_reg <= 16'h0000;
    end else if (ce) begin
      irq_request_flags_high_reg <=
        (irq_request_flags_high_reg & ~flag_clr) | flag_set;
      if (sel_mask && lane0) begin
        irq_mask_flags_high_reg <= w_data_reg[7:0] & `DMAUC_IRQ_IMPL;
      end
      // writing zero leaves the status untouched
      if (sel_sstart && lane0 && w_data_reg[`DMAUC_B_SER_CH1]) begin
        serial_ch1_enabled_status_reg <= 1'b1;
      end
      if (sel_mode && lane0) begin
        dma_mode_control_reg <= w_data_reg[6:0];
      end
      if (sel_sfr && lane0) begin
        sfr_addr_reg <= w_data_reg[7:0];
      end
      strobe_reg <= go;
      // requests seen while held wait here until hold drops
      if (go || !armed) begin
        pending_reg <= 1'b0;
      end else if (hw_req || sw_req) begin
        pending_reg <= 1'b1;
      end
      if (go) begin
        xfer_ram_addr_reg <= ram_addr_reg;
        xfer_wdata_reg <= mode_dir ? 16'h0000 : {8'h00, rx_data};
        ram_addr_reg <= ram_addr_reg + unit_step(mode_size);
        count_reg <= last ? 16'h0000 : count_reg - 16'h0001;
        if (last) begin
          transfer_mode_status_reg <= 1'b0;
        end
      end
      // RAM address and count writes only take while the channel is enabled
      if (channel_enable_reg) begin
        if (sel_ram && lane0) begin
          ram_addr_reg[7:0] <= w_data_reg[7:0];
        end
        if (sel_ram && lane1) begin
          ram_addr_reg[15:8] <= w_data_reg[15:8];
        end
        if (sel_cnt && lane0) begin
          count_reg[7:0] <= w_data_reg[7:0];
        end
        if (sel_cnt && lane1) begin
          count_reg[15:8] <= w_data_reg[15:8];
        end
      end
      if (sel_ctrl && lane0) begin
        channel_enable_reg <= w_data_reg[`DMAUC_B_CH_EN];
        if (!w_data_reg[`DMAUC_B_CH_EN]) begin
          transfer_mode_status_reg <= 1'b0;
        end else if (channel_enable_reg) begin
          transfer_mode_status_reg <= w_data_reg[`DMAUC_B_XFER_STAT];
        end
      end
    end
  end

  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready = !w_have_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  assign serial_ch1_enable = serial_ch1_enabled_status_reg;
  assign xfer_strobe = strobe_reg;
  assign xfer_dir = mode_dir;
  assign xfer_size = mode_size;
  assign xfer_sfr_addr = sfr_addr_reg;
  assign xfer_ram_addr = xfer_ram_addr_reg;
  assign xfer_wdata = xfer_wdata_reg;
  // channel clock runs only while enabled
  assign dma_clk_en = channel_enable_reg;
  assign irq = |(irq_request_flags_high_reg &
    ~irq_mask_flags_high_reg);

endmodule // dmauc_top

// File: tb/dmauc_rx_model.sv
`timescale 1ns/1ps
module dmauc_rx_model (
  // clock
  input wire clk,
  // receive unit outputs
  output logic rx_end,
  output logic rx_error,
  output logic [7:0] rx_data
);
  initial begin
    rx_end = 1'b0;
    rx_error = 1'b0;
    rx_data = 8'h00;
  end
  // n pulses back to back, data b counting up, or error pulses
  task automatic send(input logic [7:0] b, input int n, input bit err);
    int k;
    for (k = 0; k < n; k++) begin
      rx_end <= !err;
      rx_error <= err;
      rx_data <= b + 8'(k);
      @(posedge clk);
    end
    rx_end <= 1'b0;
    rx_error <= 1'b0;
    // stale byte inverted so nothing may rely on it
    rx_data <= ~rx_data;
  endtask
endmodule // dmauc_rx_model

// File: tb/dmauc_top_monitor.sv
`timescale 1ns/1ps
module dmauc_top_monitor (
  // clock and reset
  input wire clk,
  input wire nrst,
  // bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // serial and transfer side
  input wire rx_end,
  input wire [7:0] rx_data,
  input wire serial_ch1_enable,
  input wire xfer_strobe,
  input wire xfer_dir,
  input wire xfer_size,
  input wire [15:0] xfer_ram_addr,
  input wire [15:0] xfer_wdata,
  input wire dma_clk_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  off_no_xfer_a: assert property (!dma_clk_en |-> !xfer_strobe)
    else $error("transfer while channel disabled");
  reset_idle_a: assert property ($rose(nrst) |->
    !serial_ch1_enable && !dma_clk_en && !xfer_strobe)
    else $error("outputs not idle after reset");
  rx_data_a: assert property ($past(rx_end) && xfer_strobe && !xfer_dir
    |-> xfer_wdata == {8'h00, $past(rx_data)})
    else $error("moved byte differs from received byte");
  byte_step_a: assert property (xfer_strobe && $past(xfer_strobe)
    && !xfer_size |-> xfer_ram_addr == $past(xfer_ram_addr) + 16'h0001)
    else $error("byte address step not one");
  word_step_a: assert property (xfer_strobe && $past(xfer_strobe)
    && xfer_size |-> xfer_ram_addr == $past(xfer_ram_addr) + 16'h0002)
    else $error("word address step not two");
  ser_sticky_a: assert property (serial_ch1_enable |=> serial_ch1_enable)
    else $error("serial channel status dropped");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  rdata_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
endmodule // dmauc_top_monitor
bind dmauc_top dmauc_top_monitor dmauc_top_monitor_inst (.*);

// File: tb/dmauc_top_tb_top.sv
`timescale 1ns/1ps
`include "dmauc_map.vh"
module dmauc_top_tb_top;
  logic clk, nrst, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, rx_end, rx_error;
  logic ser_en, strobe, dir, size, clk_en, irq;
  logic [7:0] awaddr, araddr, rx_data, sfr;
  logic [31:0] wdata, rdata, v, n_strobe, sb;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] ram, wd, last_addr, last_wd;
  int miscompares = 0;
  int checks_done = 0;
  dmauc_top dmauc_top_inst (.clk(clk), .nrst(nrst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_end(rx_end),
    .rx_error(rx_error), .rx_data(rx_data), .serial_ch1_enable(ser_en),
    .xfer_strobe(strobe), .xfer_dir(dir), .xfer_size(size),
    .xfer_sfr_addr(sfr), .xfer_ram_addr(ram), .xfer_wdata(wd),
    .dma_clk_en(clk_en), .irq(irq));
  dmauc_rx_model dmauc_rx_model_inst (.clk(clk), .rx_end(rx_end),
    .rx_error(rx_error), .rx_data(rx_data));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (strobe === 1'b1) begin
    n_strobe <= n_strobe + 32'h1;
    last_addr <= ram;
    last_wd <= wd;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string w, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", w, e, g);
    end
  endtask
  // judged on the answer itself, so a late answer at the bound still counts
  task automatic tmo(logic ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH handshake exp answer got none");
      end_sim();
    end
  endtask
  // bready and rready stay high, so each answer is taken at once
  task automatic wr(logic [7:0] a, logic [31:0] d);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      i++;
    end while (bvalid !== 1'b1 && i < 64);
    r = bresp;
    tmo(bvalid);
  endtask
  task automatic rd(logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      i++;
    end while (rvalid !== 1'b1 && i < 64);
    v = rdata;
    r = rresp;
    tmo(rvalid);
  endtask
  task automatic rx(logic [7:0] b, int n, bit e);
    dmauc_rx_model_inst.send(b, n, e);
    repeat (3) @(posedge clk);
  endtask
  task automatic arm(logic [31:0] m, logic [31:0] n);
    wr(`DMAUC_OFF_OP_CTRL, 32'h80);
    wr(`DMAUC_OFF_MODE_CTRL, m);
    wr(`DMAUC_OFF_SFR_ADDR, 32'h12);
    wr(`DMAUC_OFF_RAM_ADDR, 32'h100);
    wr(`DMAUC_OFF_COUNT, n);
    wr(`DMAUC_OFF_OP_CTRL, 32'h81);
    sb = n_strobe;
  endtask
  task automatic t_regs();
    rd(`DMAUC_OFF_IRQ_FLAGS);
    chk("flags", 32'h0, v);
    rd(`DMAUC_OFF_IRQ_MASK);
    chk("mask", 32'hFF, v);
    rd(8'h40);
    chk("rresp", 32'h2, 32'(r));
    wr(8'h40, 32'h1);
    chk("bresp", 32'h2, 32'(r));
    wr(`DMAUC_OFF_SER_START, 32'h0);
    chk("ser_en", 32'h0, 32'(ser_en));
    wr(`DMAUC_OFF_SER_START, 32'h2);
    chk("ser_en", 32'h1, 32'(ser_en));
    rd(`DMAUC_OFF_SER_STATUS);
    chk("ser_stat", 32'h2, v);
    $display("test regs done");
  endtask
  task automatic t_off();
    wr(`DMAUC_OFF_OP_CTRL, 32'h1);
    rd(`DMAUC_OFF_OP_CTRL);
    chk("op", 32'h0, v);
    sb = n_strobe;
    rx(8'h3C, 1, 0);
    chk("strobes", sb, n_strobe);
    chk("clk_en", 32'h0, 32'(clk_en));
    rd(`DMAUC_OFF_IRQ_FLAGS);
    chk("flags", 32'h40, v);
    $display("test disabled done");
  endtask
  task automatic t_hw();
    wr(`DMAUC_OFF_IRQ_FLAGS, 32'hFF);
    wr(`DMAUC_OFF_IRQ_MASK, 32'h40);
    arm(32'h07, 32'h3);
    chk("clk_en", 32'h1, 32'(clk_en));
    chk("sfr", 32'h12, 32'(sfr));
    rx(8'hA5, 1, 0);
    rd(`DMAUC_OFF_OP_CTRL);
    chk("op", 32'h81, v);
    rx(8'hB0, 2, 0);
    chk("strobes", sb + 32'h3, n_strobe);
    chk("addr", 32'h102, 32'(last_addr));
    chk("data", 32'hB1, 32'(last_wd));
    rd(`DMAUC_OFF_OP_CTRL);
    chk("op", 32'h80, v);
    rd(`DMAUC_OFF_IRQ_FLAGS);
    chk("flags", 32'h48, v);
    chk("irq", 32'h1, 32'(irq));
    wr(`DMAUC_OFF_IRQ_MASK, 32'h48);
    chk("irq", 32'h0, 32'(irq));
    $display("test hardware start done");
  endtask
  task automatic t_sw();
    arm(32'h07, 32'h1);
    wr(`DMAUC_OFF_MODE_CTRL, 32'h07);
    repeat (3) @(posedge clk);
    chk("strobes", sb, n_strobe);
    wr(`DMAUC_OFF_MODE_CTRL, 32'h87);
    repeat (3) @(posedge clk);
    chk("strobes", sb + 32'h1, n_strobe);
    rd(`DMAUC_OFF_OP_CTRL);
    chk("op", 32'h80, v);
    wr(`DMAUC_OFF_MODE_CTRL, 32'h87);
    repeat (3) @(posedge clk);
    chk("strobes", sb + 32'h1, n_strobe);
    $display("test software trigger done");
  endtask
  task automatic t_hold();
    arm(32'h17, 32'h1);
    rx(8'h5A, 1, 0);
    chk("strobes", sb, n_strobe);
    wr(`DMAUC_OFF_MODE_CTRL, 32'h07);
    repeat (3) @(posedge clk);
    chk("strobes", sb + 32'h1, n_strobe);
    $display("test hold done");
  endtask
  task automatic t_src();
    wr(`DMAUC_OFF_IRQ_FLAGS, 32'hFF);
    arm(32'h00, 32'h1);
    rx(8'h11, 1, 0);
    chk("strobes", sb, n_strobe);
    rx(8'h00, 1, 1);
    rd(`DMAUC_OFF_IRQ_FLAGS);
    chk("flags", 32'hC0, v);
    chk("irq", 32'h1, 32'(irq));
    wr(`DMAUC_OFF_IRQ_FLAGS, 32'hFF);
    chk("irq", 32'h0, 32'(irq));
    $display("test source and error done");
  endtask
  task automatic t_word();
    ce <= 1'b0;
    rx(8'hC3, 1, 0);
    ce <= 1'b1;
    rd(`DMAUC_OFF_IRQ_FLAGS);
    chk("flags", 32'h0, v);
    arm(32'h67, 32'h2);
    chk("dir", 32'h1, 32'(dir));
    chk("size", 32'h1, 32'(size));
    rx(8'hC3, 2, 0);
    chk("strobes", sb + 32'h2, n_strobe);
    chk("addr", 32'h102, 32'(last_addr));
    chk("data", 32'h0, 32'(last_wd));
    rd(`DMAUC_OFF_OP_CTRL);
    chk("op", 32'h80, v);
    $display("test word and freeze done");
  endtask
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    wstrb = 4'hF;
    bready = 1'b1;
    rready = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    n_strobe = 32'h0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_off();
    t_hw();
    t_sw();
    t_hold();
    t_src();
    t_word();
    end_sim();
  end
endmodule // dmauc_top_tb_top
